// ---- pcfg_top.sv ----
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Behaviour
// R01 - All thirty-two shared pins are programmable
// R02 - Programmable pin disconnects its normal function
// R03 - Mode/direction: normal, pulled in, out, float
// R04 - Open-drain by toggling direction bit
// R05 - Both mode registers reset to zero
// R06 - Pins 7 to 9 reset to normal
// R07 - Pins 4 to 6 reset to normal
// R08 - Others pulled inputs; 1,10,22,23 pulled down
// R09 - Pins 4,5,7-9 pull up; 6 down
// R10 - Strap low in reset reverts 26, 29
// R11 - Low set: pins 0-15 at 70h,72h,74h
// R12 - High mode bit 15 is pin 31
// R13 - Low mode bits 15-0 are pins 15-0
// R14 - One direction bit per pin
// R15 - Direction bits map like mode bits
// R16 - Data drives or reflects pin, no inversion
// R17 - Software keeps data low for open-drain
// R18 - Direction resets: high FFFFh, low FC0Fh
// R19 - Input pins pass two-stage synchroniser
module pcfg_top #(
	parameter int unsigned ADDR_W = 12
) (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic                 clk_en,
	input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
	input  wire logic [2:0]           s_axi_awprot,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [ADDR_W-1:0]    s_axi_araddr,
	input  wire logic [2:0]           s_axi_arprot,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire logic [31:0]          pin_in,
	output logic [31:0]               pin_out,
	output logic [31:0]               pin_oe,
	output logic [31:0]               pin_pullup_en,
	output logic [31:0]               pin_pulldown_en,
	input  wire logic [31:0]          func_out,
	input  wire logic [31:0]          func_oe,
	output logic [31:0]               func_in,
	output logic [31:0]               pin_is_programmable,
	input  wire logic                 address_enable_strap
);
	function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
		hit = (addr[ADDR_W-1:2] == (ADDR_W-2)'(idx));
	endfunction : hit

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] st);
		merge = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
	endfunction : merge

	logic [15:0] mode_low_r;
	logic [15:0] mode_high_r;
	logic [15:0] dir_low_r;
	logic [15:0] dir_high_r;
	logic [15:0] data_low_r;
	logic [15:0] data_high_r;
	logic [31:0] pin_meta_r;
	logic [31:0] pin_sync_r;
	logic        strap_meta_r;
	logic        strap_sync_r;
	logic        strap_revert_r;

	// Write and read channel state; write address and data are taken together
	logic              wr_ready_r;
	logic              arready_r;
	logic              bvalid_r;
	logic [1:0]        bresp_r;
	logic              rvalid_r;
	logic [31:0]       rdata_r;
	logic [1:0]        rresp_r;

	logic [31:0] mode_all;
	logic [31:0] dir_all;
	logic [31:0] data_all;
	logic [31:0] pio_en;
	logic [31:0] drive_en;
	logic [31:0] pull_en;
	logic [31:0] data_view;

	assign mode_all  = {mode_high_r, mode_low_r}; // R12 R13
	assign dir_all   = {dir_high_r, dir_low_r};   // R14 R15
	assign data_all  = {data_high_r, data_low_r};

	// Strap reversion overrides whatever software programmed
	assign pio_en   = (mode_all | dir_all) & ~(strap_revert_r ? pcfg_pkg::STRAP_MASK : 32'h0000_0000); // R02 R10
	assign drive_en = pio_en & mode_all & ~dir_all;   // R03 R04
	assign pull_en  = pio_en & ~mode_all & dir_all;   // R03
	// Inputs read the pin, outputs read back the latch
	assign data_view = (drive_en & data_all) | (~drive_en & pin_sync_r); // R16

	// Write handshake
	logic              aw_take;
	logic              w_take;
	logic              wr_go;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0]       wr_data;
	logic [3:0]        wr_strb;
	logic              wr_mode_lo;
	logic              wr_mode_hi;
	logic              wr_dir_lo;
	logic              wr_dir_hi;
	logic              wr_data_lo;
	logic              wr_data_hi;
	logic              wr_mapped;

	assign aw_take = s_axi_awvalid & wr_ready_r;
	assign w_take  = s_axi_wvalid & wr_ready_r;
	assign wr_go   = aw_take & w_take;
	assign wr_addr = s_axi_awaddr;
	assign wr_data = s_axi_wdata;
	assign wr_strb = s_axi_wstrb;
	assign wr_mode_lo = wr_go & hit(wr_addr, pcfg_pkg::IDX_MODE_LOW);  // R11
	assign wr_dir_lo  = wr_go & hit(wr_addr, pcfg_pkg::IDX_DIR_LOW);   // R11
	assign wr_data_lo = wr_go & hit(wr_addr, pcfg_pkg::IDX_DATA_LOW);  // R11
	assign wr_mode_hi = wr_go & hit(wr_addr, pcfg_pkg::IDX_MODE_HIGH);
	assign wr_dir_hi  = wr_go & hit(wr_addr, pcfg_pkg::IDX_DIR_HIGH);
	assign wr_data_hi = wr_go & hit(wr_addr, pcfg_pkg::IDX_DATA_HIGH);
	assign wr_mapped  = wr_mode_lo | wr_dir_lo | wr_data_lo | wr_mode_hi | wr_dir_hi | wr_data_hi;

	// Read decode
	logic        ar_take;
	logic [15:0] rd_word;
	logic        rd_mapped;

	assign ar_take = s_axi_arvalid & arready_r;
	assign rd_word =
		hit(s_axi_araddr, pcfg_pkg::IDX_MODE_LOW)  ? mode_low_r  :
		hit(s_axi_araddr, pcfg_pkg::IDX_DIR_LOW)   ? dir_low_r   :
		hit(s_axi_araddr, pcfg_pkg::IDX_DATA_LOW)  ? data_view[15:0] :
		hit(s_axi_araddr, pcfg_pkg::IDX_MODE_HIGH) ? mode_high_r :
		hit(s_axi_araddr, pcfg_pkg::IDX_DIR_HIGH)  ? dir_high_r  :
		hit(s_axi_araddr, pcfg_pkg::IDX_DATA_HIGH) ? data_view[31:16] : 16'h0000;
	assign rd_mapped =
		hit(s_axi_araddr, pcfg_pkg::IDX_MODE_LOW) | hit(s_axi_araddr, pcfg_pkg::IDX_DIR_LOW) |
		hit(s_axi_araddr, pcfg_pkg::IDX_DATA_LOW) | hit(s_axi_araddr, pcfg_pkg::IDX_MODE_HIGH) |
		hit(s_axi_araddr, pcfg_pkg::IDX_DIR_HIGH) | hit(s_axi_araddr, pcfg_pkg::IDX_DATA_HIGH);

	// Synchronisers free of reset so pin levels are valid at release
	always_ff @(posedge aclk) begin
		if (clk_en) begin
			pin_meta_r   <= pin_in;       // R19
			pin_sync_r   <= pin_meta_r;   // R19
			strap_meta_r <= address_enable_strap;
			strap_sync_r <= strap_meta_r;
		end
	end

	// Strap is tracked while reset is held and frozen at release
	always_ff @(posedge aclk) begin
		if (clk_en && !aresetn) begin
			strap_revert_r <= ~strap_sync_r; // R10
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_low_r  <= pcfg_pkg::RST_MODE_LOW;  // R05
			mode_high_r <= pcfg_pkg::RST_MODE_HIGH; // R05
			dir_low_r   <= pcfg_pkg::RST_DIR_LOW;   // R06 R07 R08 R18
			dir_high_r  <= pcfg_pkg::RST_DIR_HIGH;  // R08 R18
			data_low_r  <= pcfg_pkg::RST_DATA;
			data_high_r <= pcfg_pkg::RST_DATA;
		end else if (clk_en) begin
			if (wr_mode_lo) mode_low_r  <= merge(mode_low_r, wr_data, wr_strb);
			if (wr_mode_hi) mode_high_r <= merge(mode_high_r, wr_data, wr_strb);
			if (wr_dir_lo)  dir_low_r   <= merge(dir_low_r, wr_data, wr_strb);
			if (wr_dir_hi)  dir_high_r  <= merge(dir_high_r, wr_data, wr_strb);
			if (wr_data_lo) data_low_r  <= merge(data_low_r, wr_data, wr_strb);
			if (wr_data_hi) data_high_r <= merge(data_high_r, wr_data, wr_strb);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_ready_r <= 1'b0;
			bvalid_r   <= 1'b0;
			bresp_r    <= pcfg_pkg::RESP_OKAY;
		end else if (clk_en) begin
			// Registered ready: one-cycle pulse once both halves wait
			wr_ready_r <= s_axi_awvalid & s_axi_wvalid & ~wr_ready_r & ~bvalid_r;
			if (wr_go) begin
				bvalid_r  <= 1'b1;
				bresp_r   <= wr_mapped ? pcfg_pkg::RESP_OKAY : pcfg_pkg::RESP_SLVERR;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h0000_0000;
			rresp_r   <= pcfg_pkg::RESP_OKAY;
		end else if (clk_en) begin
			arready_r <= s_axi_arvalid & ~arready_r & ~rvalid_r;
			if (ar_take) begin
				rvalid_r <= 1'b1;
				rdata_r  <= {16'h0000, rd_word};
				rresp_r  <= rd_mapped ? pcfg_pkg::RESP_OKAY : pcfg_pkg::RESP_SLVERR;
			end else if (rvalid_r && s_axi_rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	// Pad-side outputs registered; one cycle behind register writes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_out             <= 32'h0000_0000;
			pin_oe              <= 32'h0000_0000;
			pin_pullup_en       <= 32'h0000_0000;
			pin_pulldown_en     <= 32'h0000_0000;
			func_in             <= 32'h0000_0000;
			pin_is_programmable <= 32'h0000_0000;
		end else if (clk_en) begin
			pin_out             <= (drive_en & data_all) | (~pio_en & func_out);       // R01 R02 R16
			pin_oe              <= drive_en | (~pio_en & func_oe);                    // R02 R04
			pin_pullup_en       <= pull_en & ~pcfg_pkg::PULLDOWN_MASK;                // R08 R09
			pin_pulldown_en     <= pull_en & pcfg_pkg::PULLDOWN_MASK;                 // R08 R09
			func_in             <= pin_sync_r & ~pio_en;                              // R02
			pin_is_programmable <= pio_en;                                            // R01
		end
	end

	assign s_axi_awready = wr_ready_r;
	assign s_axi_wready  = wr_ready_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;
endmodule : pcfg_top

// ---- pcfg_pkg.sv ----
package pcfg_pkg;
	localparam int unsigned NUM_PINS     = 32;
	localparam int unsigned REG_W        = 16;
	localparam int unsigned IDX_W        = 8;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_MODE_LOW  = 8'h70;
	localparam logic [7:0] IDX_DIR_LOW   = 8'h72;
	localparam logic [7:0] IDX_DATA_LOW  = 8'h74;
	localparam logic [7:0] IDX_MODE_HIGH = 8'h76;
	localparam logic [7:0] IDX_DIR_HIGH  = 8'h78;
	localparam logic [7:0] IDX_DATA_HIGH = 8'h7a;
	localparam logic [15:0] RST_MODE_LOW  = 16'h0000;
	localparam logic [15:0] RST_MODE_HIGH = 16'h0000;
	localparam logic [15:0] RST_DIR_LOW   = 16'hfc0f;
	localparam logic [15:0] RST_DIR_HIGH  = 16'hffff;
	localparam logic [15:0] RST_DATA      = 16'h0000;
	// Pins whose pulled-input choice is a pulldown: 1, 6, 10, 22, 23
	localparam logic [31:0] PULLDOWN_MASK = 32'h00c0_0442;
	// Pins forced back to normal function by the strap: 26, 29
	localparam logic [31:0] STRAP_MASK    = 32'h2400_0000;
	localparam logic [1:0] RESP_OKAY      = 2'h0;
	localparam logic [1:0] RESP_SLVERR    = 2'h2;
	// Pin function encoding {mode, direction}
	typedef enum logic [1:0] {
		PCFG_NORMAL   = 2'b00,
		PCFG_IN_PULL  = 2'b01,
		PCFG_OUTPUT   = 2'b10,
		PCFG_IN_FLOAT = 2'b11
	} pcfg_func_t;
endpackage : pcfg_pkg

// ---- pcfg_monitor.sv ----
`timescale 1ns/1ps
module pcfg_monitor (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [31:0] func_out,
	input wire logic [31:0] func_oe,
	input wire logic [31:0] func_in,
	input wire logic [31:0] pin_out,
	input wire logic [31:0] pin_oe,
	input wire logic [31:0] pin_pullup_en,
	input wire logic [31:0] pin_pulldown_en,
	input wire logic [31:0] pin_is_programmable
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence ar_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence r_wait;
		s_axi_rvalid && !s_axi_rready;
	endsequence
	sequence b_wait;
		s_axi_bvalid && !s_axi_bready;
	endsequence
	chk_read_answer: assert property (ar_take |=> s_axi_rvalid)
		else $error("read answer missing");
	chk_rvalid_hold: assert property (r_wait |=> s_axi_rvalid)
		else $error("read data dropped");
	chk_bvalid_hold: assert property (b_wait |=> s_axi_bvalid)
		else $error("write response dropped");
	chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	// Normal pins pass the peripheral signals one cycle late
	chk_normal_pass: assert property ($past(aresetn) |->
		(((pin_oe ^ $past(func_oe)) | (pin_out ^ $past(func_out))) & ~pin_is_programmable) == 32'h0000_0000)
		else $error("normal function not passed");
	chk_func_gated: assert property ((func_in & pin_is_programmable) == 32'h0000_0000)
		else $error("peripheral sees programmable pin");
	chk_pull_prog: assert property (((pin_pullup_en | pin_pulldown_en) & ~pin_is_programmable) == 32'h0000_0000)
		else $error("pull on normal pin");
	chk_pull_side: assert property (((pin_pulldown_en & ~pcfg_pkg::PULLDOWN_MASK)
		| (pin_pullup_en & pcfg_pkg::PULLDOWN_MASK)) == 32'h0000_0000)
		else $error("wrong pull kind");
	chk_out_nopull: assert property ((pin_oe & pin_is_programmable & (pin_pullup_en | pin_pulldown_en)) == 32'h0000_0000)
		else $error("pull on driven pin");
endmodule : pcfg_monitor
bind pcfg_top pcfg_monitor mon_u (.*);

// ---- pcfg_pads.sv ----
`timescale 1ns/1ps
module pcfg_pads (
	input wire logic        aclk,
	input wire logic [31:0] pin_out,
	input wire logic [31:0] pin_oe,
	input wire logic [31:0] pin_pullup_en,
	input wire logic [31:0] pin_pulldown_en,
	input wire logic [31:0] ext_en,
	input wire logic [31:0] ext_val,
	output logic [31:0]     pin_in
);
	logic flt_r = 1'b0;
	// Undriven, unpulled pads wander so a stale level never passes
	always_ff @(posedge aclk) begin
		flt_r <= ~flt_r;
	end
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
		| (~pin_oe & ~ext_en & (pin_pullup_en | (~pin_pulldown_en & {32{flt_r}})));
endmodule : pcfg_pads

// ---- pcfg_tb_top.sv ----
`timescale 1ns/1ps
module pcfg_tb_top;
	logic        aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, address_enable_strap = 1'b1;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [3:0]  s_axi_wstrb = 4'h3;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
	logic [31:0] func_out = 32'h5555_5555, func_oe = 32'hffff_ffff;
	logic [31:0] ext_en = 32'h0000_0000, ext_val = 32'h0000_0000;
	logic [31:0] pin_in, pin_out, pin_oe, pin_pullup_en, pin_pulldown_en, func_in, pin_is_programmable;
	int          n_errors = 0, tests_run = 0, cyc = 0;

	always #2 aclk = ~aclk;
	pcfg_top #(.ADDR_W(12)) dut_u (.*);
	pcfg_pads pads_u (.*);

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	function automatic logic [11:0] ba(input logic [7:0] i);
		return {2'b00, i, 2'b00};
	endfunction : ba
	task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] er);
		logic ap, wp;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		{ap, wp} = 2'b11;
		while (ap || wp) begin
			@(posedge aclk);
			if (ap && s_axi_awready) begin
				s_axi_awvalid <= 1'b0;
				ap = 1'b0;
			end
			if (wp && s_axi_wready) begin
				s_axi_wvalid <= 1'b0;
				wp = 1'b0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		chk({30'h0, s_axi_bresp}, {30'h0, er});
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [1:0] er, input logic [31:0] m, input logic [31:0] e);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		chk(s_axi_rdata & m, e);
		chk({30'h0, s_axi_rresp}, {30'h0, er});
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : wrap_up

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			wrap_up();
		end
	end

	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ba(pcfg_pkg::IDX_MODE_LOW), 2'h0, 32'hffff_ffff, 32'h0000_0000);
		rd(ba(pcfg_pkg::IDX_MODE_HIGH), 2'h0, 32'hffff_ffff, 32'h0000_0000);
		rd(ba(pcfg_pkg::IDX_DIR_LOW), 2'h0, 32'hffff_ffff, 32'h0000_fc0f);
		rd(ba(pcfg_pkg::IDX_DIR_HIGH), 2'h0, 32'hffff_ffff, 32'h0000_ffff);
		chk(pin_is_programmable, 32'hffff_fc0f);
		chk(pin_pulldown_en, 32'h00c0_0402);
		chk(pin_pullup_en, 32'hff3f_f80d);
		chk(pin_oe, 32'h0000_03f0);
		chk(pin_out & 32'h0000_03f0, 32'h0000_0150);
		$display("test reset_defaults done");
		// Pins 0..3 take codes 00, 01, 10, 11; pins 4 and 6 pulled
		func_out <= 32'haaaa_aaaa;
		wr(ba(pcfg_pkg::IDX_MODE_LOW), 16'h000c, 2'h0);
		wr(ba(pcfg_pkg::IDX_DIR_LOW), 16'h005a, 2'h0);
		wr(ba(pcfg_pkg::IDX_DATA_LOW), 16'h0004, 2'h0);
		ext_en <= 32'h0000_0008;
		ext_val <= 32'h0000_0008;
		repeat (6) @(posedge aclk);
		chk(pin_is_programmable, 32'hffff_005e);
		chk(pin_oe, 32'h0000_ffa5);
		chk(pin_out & 32'h0000_ffa5, 32'h0000_aaa4);
		chk(pin_pulldown_en, 32'h00c0_0042);
		chk(pin_pullup_en, 32'hff3f_0010);
		rd(ba(pcfg_pkg::IDX_DATA_LOW), 2'h0, 32'h0000_005e, 32'h0000_001c);
		$display("test low_bank_codes done");
		// Data held low, direction toggled: drive low or float
		wr(ba(pcfg_pkg::IDX_DATA_LOW), 16'h0000, 2'h0);
		for (int v = 1; v >= 0; v--) begin
			wr(ba(pcfg_pkg::IDX_DIR_LOW), 16'h005a | {13'h0, v[0], 2'b00}, 2'h0);
			repeat (2) @(posedge aclk);
			chk({30'h0, pin_oe[2], pin_out[2]}, {30'h0, ~v[0], 1'b0});
		end
		$display("test open_drain done");
		wr(ba(pcfg_pkg::IDX_MODE_HIGH), 16'h8000, 2'h0);
		wr(ba(pcfg_pkg::IDX_DIR_HIGH), 16'h7fff, 2'h0);
		wr(ba(pcfg_pkg::IDX_DATA_HIGH), 16'h8000, 2'h0);
		repeat (2) @(posedge aclk);
		chk({27'h0, pin_oe[31], pin_out[31], pin_pullup_en[30], pin_pulldown_en[22], pin_is_programmable[31]},
			32'h0000_001f);
		rd(ba(pcfg_pkg::IDX_DATA_HIGH), 2'h0, 32'h0000_8000, 32'h0000_8000);
		$display("test high_bank done");
		// Word between two registers must be refused and leave the low mode register intact
		wr(12'h1c4, 16'hffff, pcfg_pkg::RESP_SLVERR);
		rd(12'h1c4, pcfg_pkg::RESP_SLVERR, 32'hffff_ffff, 32'h0000_0000);
		rd(ba(pcfg_pkg::IDX_MODE_LOW), 2'h0, 32'hffff_ffff, 32'h0000_000c);
		$display("test unmapped done");
		address_enable_strap <= 1'b0;
		func_oe <= 32'h0400_0000;
		aresetn <= 1'b0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		wr(ba(pcfg_pkg::IDX_MODE_HIGH), 16'hffff, 2'h0);
		repeat (2) @(posedge aclk);
		chk(pin_is_programmable, 32'hdbff_fc0f);
		chk(pin_oe & 32'h2400_0000, 32'h0400_0000);
		address_enable_strap <= 1'b1;
		$display("test strap_revert done");
		wrap_up();
	end
endmodule : pcfg_tb_top
